// ### include/rcfs_cfg.svh
`ifndef RCFS_CFG_SVH
`define RCFS_CFG_SVH
`define RCFS_CLK_HZ 20000000
`define RCFS_BLANK_US 1000
`define RCFS_REM_HOLD_US 50000
`define RCFS_OT_BLANK_US 100
`define RCFS_AREC_MS 1000
`define RCFS_BLANK_CYC ((`RCFS_BLANK_US * (`RCFS_CLK_HZ / 1000000)))
`define RCFS_REM_HOLD_CYC ((`RCFS_REM_HOLD_US * (`RCFS_CLK_HZ / 1000000)))
`define RCFS_OT_BLANK_CYC ((`RCFS_OT_BLANK_US * (`RCFS_CLK_HZ / 1000000)))
`define RCFS_AREC_CYC ((`RCFS_AREC_MS * (`RCFS_CLK_HZ / 1000)))
`define RCFS_CNT_W 26
`endif

// ### include/rcfs_pkg.sv
package rcfs_pkg;
    typedef enum logic [3:0] {
        RCFS_CHARGE = 4'h0,
        RCFS_BLANK = 4'h1,
        RCFS_RUN = 4'h3,
        RCFS_SKIP = 4'h2,
        RCFS_WAIT = 4'h6,
        RCFS_AREC = 4'h7,
        RCFS_LATCH = 4'h5,
        RCFS_OFF = 4'h4
    } rcfs_state_t;

    // Digitised comparator outputs
    typedef struct packed {
        logic supply_start_level;
        logic supply_stop_level;
        logic line_good;
        logic overvolt_overtemp_input;
        logic feedback_below_skip;
        logic feedback_above_skip_exit;
        logic feedback_below_front_stage;
        logic overload;
        logic remote_off_input;
    } rcfs_cmp_t;

    // Block enables
    typedef struct packed {
        logic line_sense_block;
        logic feedback_block;
        logic fault_block;
        logic front_stage_control;
        logic gate_drive_outputs;
        logic startup_source;
        logic self_supply_cycling;
        logic remote_pulldown;
        logic ot_blank;
    } rcfs_en_t;
endpackage

// ### hw/rcfs_sequencer.sv
`timescale 1ns/1ns
`include "rcfs_cfg.svh"
module rcfs_sequencer #(
    parameter int BLANK_CYC = `RCFS_BLANK_CYC,
    parameter int REM_HOLD_CYC = `RCFS_REM_HOLD_CYC,
    parameter int OT_BLANK_CYC = `RCFS_OT_BLANK_CYC,
    parameter int AREC_CYC = `RCFS_AREC_CYC,
    parameter bit REMOTE_VARIANT = 1'b1
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire rcfs_pkg::rcfs_cmp_t CMP_IN,
    output rcfs_pkg::rcfs_en_t EN_OUT,
    output rcfs_pkg::rcfs_state_t STATE
);
    import rcfs_pkg::*;
    localparam int CW = `RCFS_CNT_W;

    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    // Comparators are asynchronous to REF_CLK; a change counts once
    // stages two and three agree, which also filters one-cycle glitches
    rcfs_cmp_t s1, s2, s3, cmp, next_cmp;
    always_comb begin
        next_cmp = cmp;
        if (s2 == s3) begin
            next_cmp = s3;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            cmp <= '0;
        end else begin
            s1 <= CMP_IN;
            s2 <= s1;
            s3 <= s2;
            cmp <= next_cmp;
        end
    end

    // Rising edge of start level, from the filtered copy only
    logic start_d, start_ev;
    assign start_ev = cmp.supply_start_level & ~start_d;

    // --------------------------------------------------------------
    // Sequencer state and timers
    // --------------------------------------------------------------
    rcfs_state_t state, next_state;
    logic [CW-1:0] blank_cnt, next_blank_cnt;
    logic [CW-1:0] rem_cnt, next_rem_cnt;
    logic [CW-1:0] ot_cnt, next_ot_cnt;
    logic [CW-1:0] arec_cnt, next_arec_cnt;
    logic first_blank, next_first_blank;
    logic recharge, next_recharge;

    function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
        dec = (v != '0) ? v - 1'b1 : v;
    endfunction

    logic blank_done, fault_now;
    assign blank_done = (state == RCFS_BLANK) && (blank_cnt == '0);
    // Overtemp masked during its own blank window
    assign fault_now = cmp.overvolt_overtemp_input & (ot_cnt == '0);

    always_comb begin
        next_state = state;
        next_blank_cnt = dec(blank_cnt);
        next_rem_cnt = dec(rem_cnt);
        next_ot_cnt = dec(ot_cnt);
        next_arec_cnt = dec(arec_cnt);
        next_first_blank = first_blank;
        next_recharge = recharge;
        if (state == RCFS_LATCH) begin
            // Only the release reset leaves the latch
            next_state = RCFS_LATCH;
        end else if (start_ev && state != RCFS_OFF && state != RCFS_RUN && state != RCFS_SKIP) begin
            next_state = RCFS_BLANK;
            next_blank_cnt = CW'(BLANK_CYC);
            next_rem_cnt = CW'(REM_HOLD_CYC);
            next_ot_cnt = CW'(OT_BLANK_CYC);
            next_recharge = 1'b0;
        end else begin
            unique case (state)
                RCFS_CHARGE: begin
                    next_recharge = 1'b1;
                end
                RCFS_BLANK: begin
                    if (blank_done) begin
                        next_first_blank = 1'b0;
                        if (!cmp.line_good) begin
                            next_state = RCFS_WAIT;
                        end else if (cmp.overvolt_overtemp_input) begin
                            next_state = RCFS_WAIT;
                        end else if (first_blank && cmp.feedback_below_skip) begin
                            next_state = RCFS_WAIT;
                        end else begin
                            next_state = RCFS_RUN;
                        end
                    end
                end
                RCFS_RUN, RCFS_SKIP: begin
                    if (fault_now) begin
                        next_state = RCFS_LATCH;
                    end else if (REMOTE_VARIANT && cmp.remote_off_input && rem_cnt == '0) begin
                        next_state = RCFS_OFF;
                    end else if (!cmp.line_good) begin
                        next_state = RCFS_WAIT;
                    end else if (cmp.overload) begin
                        next_state = RCFS_AREC;
                        next_arec_cnt = CW'(AREC_CYC);
                    end else if (state == RCFS_SKIP && cmp.supply_stop_level) begin
                        next_state = REMOTE_VARIANT ? RCFS_CHARGE : RCFS_OFF;
                    end else if (state == RCFS_RUN && cmp.feedback_below_skip) begin
                        next_state = RCFS_SKIP;
                    end else if (state == RCFS_SKIP && cmp.feedback_above_skip_exit) begin
                        next_state = RCFS_RUN;
                        next_ot_cnt = CW'(OT_BLANK_CYC);
                    end
                end
                RCFS_WAIT: begin
                    // Recharge once every blocking condition is gone
                    if (cmp.line_good && !cmp.overvolt_overtemp_input && !cmp.feedback_below_skip) begin
                        next_state = RCFS_CHARGE;
                    end
                end
                RCFS_AREC: begin
                    if (arec_cnt == '0) begin
                        next_state = RCFS_CHARGE;
                    end
                end
                RCFS_OFF: begin
                    // Remote pulled low again: recharge for a new start
                    if (REMOTE_VARIANT && !cmp.remote_off_input) begin
                        next_state = RCFS_CHARGE;
                    end
                end
                default: begin
                    next_state = RCFS_CHARGE;
                end
            endcase
        end
    end

    // SRST is driven when supply falls under release level
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state <= RCFS_CHARGE;
            blank_cnt <= '0;
            rem_cnt <= '0;
            ot_cnt <= '0;
            arec_cnt <= '0;
            first_blank <= 1'b1;
            recharge <= 1'b0;
            start_d <= 1'b0;
        end else begin
            state <= next_state;
            blank_cnt <= next_blank_cnt;
            rem_cnt <= next_rem_cnt;
            ot_cnt <= next_ot_cnt;
            arec_cnt <= next_arec_cnt;
            first_blank <= next_first_blank;
            recharge <= next_recharge;
            start_d <= cmp.supply_start_level;
        end
    end

    // --------------------------------------------------------------
    // Block enables, registered so outputs are glitch free
    // --------------------------------------------------------------
    rcfs_en_t en, next_en;
    always_comb begin
        next_en = '0;
        // Built from the next counts so the marks rise with the blank itself
        next_en.remote_pulldown = (next_rem_cnt != '0) && next_state != RCFS_OFF;
        next_en.ot_blank = (next_ot_cnt != '0);
        unique case (next_state)
            RCFS_CHARGE: begin
                next_en.startup_source = 1'b1;
                next_en.line_sense_block = 1'b1;
                next_en.feedback_block = 1'b1;
                next_en.front_stage_control = 1'b1;
            end
            RCFS_BLANK, RCFS_RUN: begin
                next_en.line_sense_block = 1'b1;
                next_en.feedback_block = 1'b1;
                next_en.fault_block = 1'b1;
                next_en.front_stage_control = ~cmp.feedback_below_front_stage;
                next_en.gate_drive_outputs = (next_state == RCFS_RUN);
            end
            RCFS_SKIP: begin
                next_en.feedback_block = 1'b1;
            end
            RCFS_WAIT: begin
                next_en.line_sense_block = 1'b1;
                next_en.feedback_block = 1'b1;
                next_en.fault_block = cmp.line_good;
                next_en.front_stage_control = 1'b1;
                next_en.self_supply_cycling = 1'b1;
            end
            RCFS_AREC: begin
                next_en.feedback_block = 1'b1;
                next_en.fault_block = 1'b1;
                next_en.self_supply_cycling = 1'b1;
            end
            RCFS_LATCH: begin
                next_en.feedback_block = 1'b1;
                next_en.self_supply_cycling = 1'b1;
                next_en.remote_pulldown = 1'b0;
            end
            RCFS_OFF: begin
                next_en.self_supply_cycling = 1'b1;
            end
            default: begin
                next_en = '0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            en <= '0;
        end else begin
            en <= next_en;
        end
    end

    assign EN_OUT = en;
    assign STATE = state;
endmodule // rcfs_sequencer

// ### sim/rcfs_checker.sv
`timescale 1ns/1ns
module rcfs_checker #(
    parameter int BLANK_CYC = 16,
    parameter int AREC_CYC = 32
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire rcfs_pkg::rcfs_cmp_t CMP_IN,
    input wire rcfs_pkg::rcfs_en_t EN_OUT,
    input wire rcfs_pkg::rcfs_state_t STATE
);
    import rcfs_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    // -------------------------
    // Dwell counter per state
    // -------------------------
    logic [7:0] dwell;
    logic [7:0] next_dwell;
    rcfs_state_t last;
    rcfs_state_t next_last;
    // Saturates so long stays never wrap
    always_comb begin
        next_last = STATE;
        next_dwell = (SRST || STATE != last) ? 8'h00 : dwell + {7'h00, dwell != 8'hFF};
    end
    always_ff @(posedge REF_CLK) begin
        dwell <= next_dwell;
        last <= next_last;
    end
    sequence s_blank_enter;
        STATE != RCFS_BLANK ##1 STATE == RCFS_BLANK;
    endsequence
    sequence s_settled(rcfs_state_t s);
        STATE == s && last == s;
    endsequence
    chk_blank_marks:
    assert property (s_blank_enter |-> EN_OUT.remote_pulldown && EN_OUT.ot_blank) else $error("blank entry marks");
    chk_blank_min:
    assert property (s_settled(RCFS_BLANK) and dwell < BLANK_CYC - 4 |=> STATE == RCFS_BLANK) else $error("blank short");
    chk_blank_max:
    assert property (s_settled(RCFS_BLANK) |-> dwell <= BLANK_CYC + 2) else $error("blank long");
    chk_arec_min:
    assert property (s_settled(RCFS_AREC) and dwell < AREC_CYC - 4 |=> STATE == RCFS_AREC) else $error("recovery short");
    chk_arec_max:
    assert property (s_settled(RCFS_AREC) |-> dwell <= AREC_CYC + 2) else $error("recovery long");
    chk_latch_hold:
    assert property (STATE == RCFS_LATCH |=> STATE == RCFS_LATCH) else $error("latch left");
    chk_latch_outputs:
    assert property (s_settled(RCFS_LATCH) |-> EN_OUT.feedback_block && !EN_OUT.gate_drive_outputs
        && !EN_OUT.line_sense_block && EN_OUT.self_supply_cycling) else $error("latch outputs");
    chk_no_drive:
    assert property (STATE inside {RCFS_BLANK, RCFS_WAIT, RCFS_AREC, RCFS_LATCH, RCFS_OFF}
        |-> !EN_OUT.gate_drive_outputs) else $error("drivers on");
    chk_wait_bias:
    assert property (STATE == RCFS_WAIT |-> EN_OUT.front_stage_control && EN_OUT.self_supply_cycling)
        else $error("wait bias");
    chk_off_quiet:
    assert property (STATE == RCFS_OFF |-> !EN_OUT.feedback_block) else $error("off feedback");
    chk_charge_source:
    assert property (STATE == RCFS_CHARGE [*3] |-> EN_OUT.startup_source) else $error("charge source");
    chk_run_nosource:
    assert property (STATE == RCFS_RUN |-> !EN_OUT.startup_source) else $error("run source");
endmodule // rcfs_checker
bind rcfs_sequencer rcfs_checker #(.BLANK_CYC(BLANK_CYC), .AREC_CYC(AREC_CYC)) chk_u (.REF_CLK(REF_CLK),
    .SRST(SRST), .CMP_IN(CMP_IN), .EN_OUT(EN_OUT), .STATE(STATE));

// ### sim/rcfs_partner.sv
`timescale 1ns/1ns
module rcfs_partner #(
    parameter int CHG_CYC = 6
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire rcfs_pkg::rcfs_en_t EN_OUT,
    output logic START_LVL
);
    import rcfs_pkg::*;
    logic [7:0] cnt = 8'h00;
    logic src_d = 1'b0;
    initial START_LVL = 1'b0;
    // Supply ramps while the startup source runs; a fresh charge restarts the ramp
    always @(negedge REF_CLK) begin
        src_d <= EN_OUT.startup_source;
        if (SRST || (EN_OUT.startup_source && !src_d)) begin
            cnt <= 8'h00;
            START_LVL <= 1'b0;
        end else if (EN_OUT.startup_source && !START_LVL) begin
            cnt <= cnt + 8'h01;
            START_LVL <= (cnt == CHG_CYC);
        end
    end
endmodule // rcfs_partner

// ### sim/rcfs_sequencer_test.sv
`timescale 1ns/1ns
module rcfs_sequencer_test;
    import rcfs_pkg::*;
    logic REF_CLK = 1'b0;
    logic SRST = 1'b1;
    rcfs_cmp_t tb_cmp = '0;
    rcfs_cmp_t cmp_in;
    logic start_lvl;
    rcfs_en_t en;
    rcfs_state_t st;
    int n_errors = 0;
    int n_tests = 0;
    always #25 REF_CLK = ~REF_CLK;
    // Supply level comes from the partner, the rest from the scenarios
    always_comb begin
        cmp_in = tb_cmp;
        cmp_in.supply_start_level = start_lvl;
    end
    rcfs_sequencer #(.BLANK_CYC(16), .REM_HOLD_CYC(24), .OT_BLANK_CYC(8), .AREC_CYC(32), .REMOTE_VARIANT(1'b1))
        dut_u (.REF_CLK(REF_CLK), .SRST(SRST), .CMP_IN(cmp_in), .EN_OUT(en), .STATE(st));
    rcfs_partner prt_u (.REF_CLK(REF_CLK), .SRST(SRST), .EN_OUT(en), .START_LVL(start_lvl));
    // -------------------------
    // Shared checking helpers
    // -------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bounded wait; a miss ends the run
    task wait_st(input rcfs_state_t s);
        for (int i = 0; i < 400 && st !== s; i++) @(negedge REF_CLK);
        if (st !== s) begin
            n_errors++;
            summarize();
        end
    endtask
    task s_brownout;
        wait_st(RCFS_BLANK);
        check({en.line_sense_block, en.feedback_block, en.fault_block, en.front_stage_control}, 4'hF);
        check(en.remote_pulldown, 1'b1);
        wait_st(RCFS_WAIT);
        check({en.gate_drive_outputs, en.front_stage_control, en.self_supply_cycling}, 3'h3);
        @(negedge REF_CLK) tb_cmp.line_good = 1'b1;
        wait_st(RCFS_CHARGE);
        check(en.startup_source, 1'b1);
        wait_st(RCFS_RUN);
        check(en.gate_drive_outputs, 1'b1);
        @(negedge REF_CLK) tb_cmp.line_good = 1'b0;
        wait_st(RCFS_WAIT);
        check({en.gate_drive_outputs, en.fault_block, en.front_stage_control}, 3'h1);
        @(negedge REF_CLK) tb_cmp.line_good = 1'b1;
        wait_st(RCFS_RUN);
    endtask
    task s_skip;
        @(negedge REF_CLK) tb_cmp.feedback_below_front_stage = 1'b1;
        repeat (8) @(negedge REF_CLK);
        check(en.front_stage_control, 1'b0);
        tb_cmp.feedback_below_skip = 1'b1;
        wait_st(RCFS_SKIP);
        check({en.gate_drive_outputs, en.feedback_block, en.fault_block}, 3'h2);
        @(negedge REF_CLK) tb_cmp.feedback_below_skip = 1'b0;
        tb_cmp.feedback_above_skip_exit = 1'b1;
        wait_st(RCFS_RUN);
        check({en.startup_source, en.ot_blank, en.gate_drive_outputs}, 3'h3);
        @(negedge REF_CLK) tb_cmp.feedback_above_skip_exit = 1'b0;
        tb_cmp.feedback_below_front_stage = 1'b0;
    endtask
    task s_overload;
        @(negedge REF_CLK) tb_cmp.overload = 1'b1;
        wait_st(RCFS_AREC);
        check({en.gate_drive_outputs, en.feedback_block, en.fault_block, en.self_supply_cycling}, 4'h7);
        @(negedge REF_CLK) tb_cmp.overload = 1'b0;
        wait_st(RCFS_CHARGE);
        check(en.startup_source, 1'b1);
        wait_st(RCFS_BLANK);
        check({en.ot_blank, en.remote_pulldown}, 2'h3);
        wait_st(RCFS_RUN);
    endtask
    task s_remote_off;
        repeat (30) @(negedge REF_CLK);
        tb_cmp.remote_off_input = 1'b1;
        wait_st(RCFS_OFF);
        check({en.feedback_block, en.gate_drive_outputs}, 2'h0);
        @(negedge REF_CLK) tb_cmp.remote_off_input = 1'b0;
        wait_st(RCFS_RUN);
    endtask
    task s_latch;
        repeat (20) @(negedge REF_CLK);
        tb_cmp.overvolt_overtemp_input = 1'b1;
        wait_st(RCFS_LATCH);
        check({en.feedback_block, en.gate_drive_outputs, en.self_supply_cycling}, 3'h5);
        @(negedge REF_CLK) tb_cmp.overvolt_overtemp_input = 1'b0;
        tb_cmp.overload = 1'b1;
        repeat (20) @(negedge REF_CLK);
        check(st, RCFS_LATCH);
        tb_cmp.overload = 1'b0;
        SRST = 1'b1;
        repeat (2) @(negedge REF_CLK);
        check(st, RCFS_CHARGE);
    endtask
    initial begin
        repeat (5) @(negedge REF_CLK);
        SRST = 1'b0;
        s_brownout();
        s_skip();
        s_overload();
        s_remote_off();
        s_latch();
        summarize();
    end
endmodule // rcfs_sequencer_test
